//--- include/cmr_pkg.sv
// package for the comparator mode and reference control block
//
// Contract
// [R1] raw result is high when positive input exceeds negative input
// [R2] output_invert set presents inverted raw result, clear presents it unchanged
// [R3] eight comparator modes selected by comparator_mode_field
// [R4] software should mask the comparator interrupt while changing the mode
// [R5] comparator_result is read-only in comparator_control_reg
// [R6] three modes drive comparator_result combinationally onto the output pin
// [R7] pin direction bit acts as output enable in output modes
// [R8] port_a_value reads analog-configured pins as zero
// [R9] four modes route the internal reference to a comparator input
// [R10] 32 reference levels, range select 1 low, 0 high, 4-bit level
// [R11] software waits the response time after changing reference or input
// [R12] enabled comparator and reference keep running through sleep
// [R13] mode 111 turns comparator off; clearing reference enable powers it down
// [R14] comparator interrupt wakes the device while enabled in sleep
// [R15] wake from sleep leaves both control registers unchanged
// [R16] change flag set on result change, set by writing 1, cleared writing 0
// [R17] result mismatch keeps setting flag; access to control reg updates latch
// [R18] reset forces mode 000 and reference off
// [R19] fixed per-mode routing of input pins, reference and output pin
package cmr_pkg;
   // register word indices (printed offsets are not all multiples of four)
   localparam logic [7:0] CMR_IDX_CTRL = 8'h19;
   localparam logic [7:0] CMR_IDX_VREF = 8'h99;
   localparam logic [7:0] CMR_IDX_DIR = 8'h85;
   localparam logic [7:0] CMR_IDX_PORT = 8'h05;
   localparam logic [7:0] CMR_IDX_IRQ_STAT = 8'h0c;
   localparam logic [7:0] CMR_IDX_IRQ_EN = 8'h8c;
   localparam logic [7:0] CMR_IDX_IRQ_CLR = 8'h8d;
   localparam logic [7:0] CMR_IDX_FLAG = 8'h0d;
   // control register fields
   localparam int CMR_CTRL_RES_BIT = 6;
   localparam int CMR_CTRL_INV_BIT = 4;
   localparam int CMR_CTRL_CIS_BIT = 3;
   localparam logic [7:0] CMR_CTRL_WMASK = 8'h1f;
   localparam logic [7:0] CMR_CTRL_RST = 8'h00;
   // reference register fields
   localparam int CMR_VREF_EN_BIT = 7;
   localparam int CMR_VREF_RNG_BIT = 5;
   localparam logic [7:0] CMR_VREF_WMASK = 8'haf;
   localparam logic [7:0] CMR_VREF_RST = 8'h00;
   // port a direction
   localparam logic [5:0] CMR_DIR_RST = 6'h3f;
   localparam int CMR_OUT_PIN = 2;
   // interrupt status bits
   localparam int CMR_EV_CHANGE = 0;
   localparam int CMR_EV_NUM = 1;
   // mode codes
   localparam logic [2:0] CMR_MODE_RESET = 3'h0;
   localparam logic [2:0] CMR_MODE_OFF = 3'h7;
   localparam int CMR_MODES = 8;

   // per-mode routing: analog pin mask, reference use, output drive, comparator on
   typedef struct packed {
      logic [5:0] analog;
      logic use_ref;
      logic drive_out;
      logic on;
   } cmr_route_t;

   function automatic cmr_route_t cmr_route(input logic [2:0] mode);
      cmr_route_t r;
      r = '{analog: 6'h00, use_ref: 1'b0, drive_out: 1'b0, on: 1'b1};
      case (mode)
         3'h0: r = '{analog: 6'h07, use_ref: 1'b0, drive_out: 1'b0, on: 1'b0};
         3'h1: r = '{analog: 6'h03, use_ref: 1'b0, drive_out: 1'b1, on: 1'b1};
         3'h2: r = '{analog: 6'h03, use_ref: 1'b0, drive_out: 1'b0, on: 1'b1};
         3'h3: r = '{analog: 6'h01, use_ref: 1'b1, drive_out: 1'b1, on: 1'b1};
         3'h4: r = '{analog: 6'h03, use_ref: 1'b1, drive_out: 1'b0, on: 1'b1};
         3'h5: r = '{analog: 6'h02, use_ref: 1'b1, drive_out: 1'b1, on: 1'b1};
         3'h6: r = '{analog: 6'h01, use_ref: 1'b1, drive_out: 1'b0, on: 1'b1};
         default: r = '{analog: 6'h00, use_ref: 1'b0, drive_out: 1'b0, on: 1'b0};
      endcase
      return r;
   endfunction
endpackage

//--- core/cmr_ref_ctl.sv
// reference ladder tap selection
`timescale 1ns/1ps
module cmr_ref_ctl
   import cmr_pkg::*;
#(
   parameter int LEVEL_W = 4
)
(
   // configuration
   input wire logic ref_en,
   input wire logic range_low,
   input wire logic [LEVEL_W-1:0] level,
   // ladder control
   output logic ladder_on,
   output logic [5:0] tap_sel
);
   // low range taps 0..15, high range taps 16..31: 32 levels in all
   assign ladder_on = ref_en; // R13
   assign tap_sel = ref_en ? {1'b0, ~range_low, level} : 6'h00; // R10
endmodule

//--- core/cmr_flag.sv
// sticky change flag with set-over-clear priority
`timescale 1ns/1ps
module cmr_flag
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // events
   input wire logic set_ev,
   input wire logic clr,
   input wire logic sw_set,
   // state
   output logic flag
);
   logic flag_q;
   logic flag_d;
   // hardware set wins over a clear in the same cycle
   assign flag_d = set_ev | sw_set | (flag_q & ~clr); // R16
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         flag_q <= 1'b0;
      else
         flag_q <= flag_d;
   end
   assign flag = flag_q;
endmodule

//--- core/cmr_top.sv
// comparator mode, polarity, output pin and reference control with apb registers
`timescale 1ns/1ps
module cmr_top
   import cmr_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog front end
   input wire logic comp_raw,
   input wire logic [5:0] port_a_pins,
   output logic comp_on,
   output logic ref_to_input,
   output logic neg_from_cis,
   output logic [5:0] analog_sel,
   output logic ladder_on,
   output logic [5:0] ladder_tap,
   // comparator output pin
   output logic comparator_output_pin_o,
   output logic comparator_output_pin_oe,
   // power and interrupt
   input wire logic sleep,
   output logic wake,
   output logic irq
);
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] vref_q;
   logic [7:0] vref_d;
   logic [5:0] dir_q;
   logic [5:0] dir_d;
   logic [CMR_EV_NUM-1:0] ien_q;
   logic [CMR_EV_NUM-1:0] ien_d;
   logic latch_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic err_q;

   // apb decode: single-cycle access phase, always ready
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire lane0 = pstrb[0];
   wire [9:0] idx = paddr[11:2];
   wire hit_ctrl = (idx == {2'b00, CMR_IDX_CTRL});
   wire hit_vref = (idx == {2'b00, CMR_IDX_VREF});
   wire hit_dir = (idx == {2'b00, CMR_IDX_DIR});
   wire hit_port = (idx == {2'b00, CMR_IDX_PORT});
   wire hit_stat = (idx == {2'b00, CMR_IDX_IRQ_STAT});
   wire hit_ien = (idx == {2'b00, CMR_IDX_IRQ_EN});
   wire hit_iclr = (idx == {2'b00, CMR_IDX_IRQ_CLR});
   wire hit_flag = (idx == {2'b00, CMR_IDX_FLAG});
   wire mapped = hit_ctrl | hit_vref | hit_dir | hit_port | hit_stat | hit_ien
      | hit_iclr | hit_flag;

   // mode routing from the fixed per-mode table
   wire [2:0] mode = ctrl_q[2:0]; // R3
   cmr_route_t route;
   assign route = cmr_route(mode); // R19

   // comparator result, inverted on request; combinational path to the pin
   wire raw_gated = comp_raw & route.on; // R1 R13
   wire result = raw_gated ^ ctrl_q[CMR_CTRL_INV_BIT]; // R2
   assign comparator_output_pin_o = result & route.drive_out; // R6
   assign comparator_output_pin_oe = route.drive_out & ~dir_q[CMR_OUT_PIN]; // R7

   // pin drive: only output modes with the direction bit cleared may drive; the pin
   // level is checked against the raw input, not against the internal result wire
   AST_PIN_DRIVE: assert property (@(posedge sys_clk) disable iff (!nrst) // R6
      !route.drive_out |-> !comparator_output_pin_oe && !comparator_output_pin_o)
      else $error("pin driven outside output mode");
   AST_PIN_OE: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
      dir_q[CMR_OUT_PIN] |-> !comparator_output_pin_oe)
      else $error("pin driven while direction is input");
   AST_PIN_FOLLOW: assert property (@(posedge sys_clk) disable iff (!nrst) // R6
      comparator_output_pin_oe |-> comparator_output_pin_o == (comp_raw ^ ctrl_q[CMR_CTRL_INV_BIT]))
      else $error("pin level does not follow the comparator");
   AST_ROUTE_OUT: assert property (@(posedge sys_clk) disable iff (!nrst) // R6
      comparator_output_pin_oe |-> mode == 3'h1 || mode == 3'h3 || mode == 3'h5)
      else $error("pin driven in a mode without output");

   // analog routing outputs; nothing here depends on sleep, so both keep running
   assign comp_on = route.on; // R12 R13
   assign ref_to_input = route.use_ref; // R9
   assign neg_from_cis = ctrl_q[CMR_CTRL_CIS_BIT];
   assign analog_sel = route.analog;

   // mode decode against the mode codes themselves
   AST_OFF_MODE: assert property (@(posedge sys_clk) disable iff (!nrst) // R13
      mode == CMR_MODE_OFF |-> !comp_on && !comparator_output_pin_oe)
      else $error("comparator on in off mode");
   AST_RESET_MODE: assert property (@(posedge sys_clk) disable iff (!nrst) // R18
      mode == CMR_MODE_RESET |-> !comp_on && !comparator_output_pin_oe)
      else $error("comparator active in reset mode");
   AST_REF_ROUTE: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
      ref_to_input |-> mode >= 3'h3 && mode <= 3'h6)
      else $error("reference routed in an external mode");
   AST_SLEEP_RUN: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
      sleep && mode != CMR_MODE_OFF && mode != CMR_MODE_RESET |-> comp_on)
      else $error("comparator gated off in sleep");

   cmr_ref_ctl #(
      .LEVEL_W(4)
   ) u_ref (
      .ref_en(vref_q[CMR_VREF_EN_BIT]),
      .range_low(vref_q[CMR_VREF_RNG_BIT]),
      .level(vref_q[3:0]),
      .ladder_on(ladder_on),
      .tap_sel(ladder_tap)
   ); // R10 R12 R13

   // ladder power and tap follow the reference register, sleep or not
   AST_REF_OFF: assert property (@(posedge sys_clk) disable iff (!nrst) // R13
      !vref_q[CMR_VREF_EN_BIT] |-> !ladder_on && ladder_tap == 6'h00)
      else $error("reference powered while disabled");
   AST_REF_TAP: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
      ladder_on |-> ladder_tap == {1'b0, !vref_q[CMR_VREF_RNG_BIT], vref_q[3:0]})
      else $error("reference tap wrong");
   AST_SLEEP_REF: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
      sleep && vref_q[CMR_VREF_EN_BIT] |-> ladder_on)
      else $error("reference gated off in sleep");

   // mismatch against the latched result; any control access refreshes the latch
   wire ctrl_acc = acc & hit_ctrl;
   wire mismatch = (result != latch_q); // R17
   wire flag_sw_wr = wr & hit_flag & lane0;
   wire flag_sw_set = flag_sw_wr & pwdata[0];
   wire flag_sw_clr = flag_sw_wr & ~pwdata[0];
   wire stat_clr = wr & hit_iclr & lane0 & pwdata[CMR_EV_CHANGE];
   logic change_flag;
   logic stat_change;

   cmr_flag u_change_flag (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .set_ev(mismatch),
      .clr(flag_sw_clr),
      .sw_set(flag_sw_set),
      .flag(change_flag)
   ); // R16 R17

   // flag: a standing mismatch beats a software clear; without one a clear sticks
   // and a set by software holds until cleared
   AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
      mismatch |=> change_flag)
      else $error("change flag missed");
   AST_FLAG_CLR: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
      flag_sw_clr && !mismatch |=> !change_flag)
      else $error("change flag not cleared");
   AST_FLAG_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
      change_flag && !flag_sw_clr |=> change_flag)
      else $error("change flag lost without clear");
   AST_FLAG_SW_SET: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
      flag_sw_set |=> change_flag)
      else $error("software set of change flag ignored");

   // status copy for the interrupt controller, cleared by the clear register
   cmr_flag u_stat_change (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .set_ev(mismatch),
      .clr(stat_clr),
      .sw_set(1'b0),
      .flag(stat_change)
   );
   // status copy: same set, own clear through the clear register
   AST_STAT_SET: assert property (@(posedge sys_clk) disable iff (!nrst) // R17
      mismatch |=> stat_change)
      else $error("status bit missed");
   AST_STAT_CLR: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
      stat_clr && !mismatch |=> !stat_change)
      else $error("status bit not cleared");
   AST_STAT_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
      stat_change && !stat_clr |=> stat_change)
      else $error("status bit lost without clear");

   // interrupt level and wake; sleep does not alter registers
   assign irq = stat_change & ien_q[CMR_EV_CHANGE];
   assign wake = sleep & route.on & irq; // R14 R15

   // wake only out of sleep, and only for an enabled event
   AST_WAKE: assert property (@(posedge sys_clk) disable iff (!nrst) // R14
      sleep && route.on && irq |-> wake)
      else $error("no wake on interrupt");
   AST_WAKE_QUIET: assert property (@(posedge sys_clk) disable iff (!nrst) // R14
      !sleep |-> !wake)
      else $error("wake while awake");
   AST_IRQ_MASK: assert property (@(posedge sys_clk) disable iff (!nrst) // R14
      !ien_q[CMR_EV_CHANGE] |-> !irq)
      else $error("interrupt while masked");

   // register next values; result bit and reserved bits are not writable
   assign ctrl_d = (wr & hit_ctrl & lane0)
      ? (pwdata[7:0] & CMR_CTRL_WMASK) : ctrl_q; // R5
   assign vref_d = (wr & hit_vref & lane0)
      ? (pwdata[7:0] & CMR_VREF_WMASK) : vref_q;
   assign dir_d = (wr & hit_dir & lane0) ? pwdata[5:0] : dir_q;
   assign ien_d = (wr & hit_ien & lane0) ? pwdata[CMR_EV_NUM-1:0] : ien_q;

   // port read: analog-configured pins return zero
   wire [5:0] port_view = port_a_pins & ~route.analog; // R8

   // analog pins must never leak a level into a port read
   AST_PORT_ANALOG: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
      (port_view & route.analog) == 6'h00)
      else $error("analog pin read nonzero");

   // control read view: reserved bits zero, result in bit 6
   wire [7:0] ctrl_view = {1'b0, result, 1'b0, ctrl_q[4:0]}; // R5
   // result polarity, checked against the raw input while the comparator is on
   AST_INVERT: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
      ctrl_view[CMR_CTRL_RES_BIT] == (raw_gated ^ ctrl_q[CMR_CTRL_INV_BIT]))
      else $error("result polarity wrong");
   AST_RESULT_RAW: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
      route.on |-> ctrl_view[CMR_CTRL_RES_BIT] == (comp_raw ^ ctrl_q[CMR_CTRL_INV_BIT]))
      else $error("result does not follow the comparator");

   // read mux
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (hit_ctrl)
         rdata_d = {24'h00_0000, ctrl_view};
      else if (hit_vref)
         rdata_d = {24'h00_0000, vref_q};
      else if (hit_dir)
         rdata_d = {26'h000_0000, dir_q};
      else if (hit_port)
         rdata_d = {26'h000_0000, port_view};
      else if (hit_stat)
         rdata_d = {31'h0000_0000, stat_change};
      else if (hit_ien)
         rdata_d = {31'h0000_0000, ien_q};
      else if (hit_flag)
         rdata_d = {31'h0000_0000, change_flag};
   end

   // control register; reset forces the comparator reset mode
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         ctrl_q <= CMR_CTRL_RST; // R18
      else
         ctrl_q <= ctrl_d;
   end

   // reference register; reset leaves the ladder powered down
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         vref_q <= CMR_VREF_RST; // R18
      else
         vref_q <= vref_d;
   end

   // pin directions reset to input, so the output pin is released after reset
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         dir_q <= CMR_DIR_RST;
      else
         dir_q <= dir_d;
   end

   // interrupt enable resets masked
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         ien_q <= '0;
      else
         ien_q <= ien_d;
   end

   // writes land as written, the result bit never; leaving sleep changes nothing
   AST_RESULT_RO: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
      wr & hit_ctrl |=> ctrl_q[7:5] == 3'h0)
      else $error("result bit became writable");
   AST_WRITE_MODE: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
      wr && hit_ctrl && lane0 |=> mode == $past(pwdata[2:0]))
      else $error("mode write lost");
   AST_INV_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
      wr && hit_ctrl && lane0 |=> ctrl_q[CMR_CTRL_INV_BIT] == $past(pwdata[CMR_CTRL_INV_BIT]))
      else $error("invert write lost");
   AST_SLEEP_KEEP: assert property (@(posedge sys_clk) disable iff (!nrst) // R15
      $fell(sleep) && !$past(wr && hit_ctrl) |-> ctrl_q == $past(ctrl_q))
      else $error("control changed on wake");
   AST_SLEEP_VREF: assert property (@(posedge sys_clk) disable iff (!nrst) // R15
      $fell(sleep) && !$past(wr && hit_vref) |-> vref_q == $past(vref_q))
      else $error("reference changed on wake");

   // mismatch latch follows the result on any control register access
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         latch_q <= 1'b0;
      else if (ctrl_acc)
         latch_q <= result; // R17
   end

   // after a control access the mismatch lasts only if the result moved again
   AST_LATCH: assert property (@(posedge sys_clk) disable iff (!nrst) // R17
      ctrl_acc |=> latch_q == $past(result))
      else $error("latch not refreshed");
   AST_MISMATCH_END: assert property (@(posedge sys_clk) disable iff (!nrst) // R17
      ctrl_acc |=> mismatch == (result != $past(result)))
      else $error("mismatch survived a control access");

   // read data and error are captured at the edge ending the setup phase; bus sees them registered
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end
      else if (psel & ~penable)
      begin
         rdata_q <= rdata_d;
         err_q <= ~mapped;
      end
   end

   // read data is valid during the access phase since it was sampled in setup
   assign prdata = rd ? rdata_q : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = acc & err_q;

   // cover points; bus transfers are spaced, so the flag sequence allows gaps
   COV_OUT_MODE: cover property (@(posedge sys_clk) disable iff (!nrst)
      comparator_output_pin_oe && comparator_output_pin_o);
   COV_FLAG: cover property (@(posedge sys_clk) disable iff (!nrst)
      mismatch ##[1:8] ctrl_acc ##[1:8] flag_sw_clr);
   COV_SLEEP_ON: cover property (@(posedge sys_clk) disable iff (!nrst)
      sleep && comp_on && ladder_on);
   COV_UNMAPPED: cover property (@(posedge sys_clk) disable iff (!nrst)
      acc && !mapped);
   COV_WAKE: cover property (@(posedge sys_clk) disable iff (!nrst) wake);
endmodule

//--- test/cmr_analog_src.sv
// behavioural analog sources and output pin load facing the comparator block
`timescale 1ns/1ps
module cmr_analog_src
(
   // analog levels in millivolts, set by the bench
   input wire logic [11:0] vin_pos,
   input wire logic [11:0] vin_neg,
   // block state
   input wire logic comp_on,
   input wire logic pin_o,
   input wire logic pin_oe,
   // comparator decision and pin level
   output logic comp_raw,
   output logic pin_level
);
   // an unpowered comparator decides nothing; low keeps the model quiet
   assign comp_raw = comp_on & (vin_pos > vin_neg);
   // weak pull-down on the pin, so a released pin never shows a stale drive
   assign pin_level = pin_oe ? pin_o : 1'b0;
endmodule

//--- test/tb.sv
// self-checking bench for the comparator mode and reference control block
`timescale 1ns/1ps
module tb
   import cmr_pkg::*;
;
   localparam logic [11:0] A_CTRL = {2'b00, CMR_IDX_CTRL, 2'b00};
   localparam logic [11:0] A_VREF = {2'b00, CMR_IDX_VREF, 2'b00};
   localparam logic [11:0] A_DIR = {2'b00, CMR_IDX_DIR, 2'b00};
   localparam logic [11:0] A_PORT = {2'b00, CMR_IDX_PORT, 2'b00};
   localparam logic [11:0] A_EN = {2'b00, CMR_IDX_IRQ_EN, 2'b00};
   localparam logic [11:0] A_CLR = {2'b00, CMR_IDX_IRQ_CLR, 2'b00};
   localparam logic [11:0] A_FLAG = {2'b00, CMR_IDX_FLAG, 2'b00};
   logic sys_clk, nrst, psel, penable, pwrite, sleep, err;
   logic [11:0] paddr, vin_pos, vin_neg;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, comp_raw, comp_on, ref_to_input, neg_from_cis, ladder_on;
   logic [5:0] port_a_pins, analog_sel, ladder_tap;
   logic pin_o, pin_oe, pin_level, wake, irq;
   int failures, tests_run;
   // analog pins expected per mode code
   logic [5:0] amask [8] = '{6'h07, 6'h03, 6'h03, 6'h01, 6'h03, 6'h02, 6'h01, 6'h00};

   cmr_top u_cmr_top (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .comp_raw(comp_raw), .port_a_pins(port_a_pins),
      .comp_on(comp_on), .ref_to_input(ref_to_input), .neg_from_cis(neg_from_cis),
      .analog_sel(analog_sel), .ladder_on(ladder_on), .ladder_tap(ladder_tap),
      .comparator_output_pin_o(pin_o), .comparator_output_pin_oe(pin_oe),
      .sleep(sleep), .wake(wake), .irq(irq));
   cmr_analog_src u_cmr_analog_src (.vin_pos(vin_pos), .vin_neg(vin_neg),
      .comp_on(comp_on), .pin_o(pin_o), .pin_oe(pin_oe), .comp_raw(comp_raw),
      .pin_level(pin_level));

   // 200 mhz clock
   initial sys_clk = 1'b0;
   always #2.5 sys_clk = ~sys_clk;

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask

   task automatic results();
      $display("checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // one apb transfer; the idle cycle in front avoids double assignment at one edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 16)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 16)
      begin
         failures++;
         $display("wrong value pready expected 1 seen timeout");
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task automatic done(input string name);
      $display("test %s finished, mismatches so far %0d", name, failures);
   endtask

   // hang guard
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      $display("wrong value run expected finish seen timeout");
      results();
   end

   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sleep = 1'b0;
      vin_pos = 12'd1000;
      vin_neg = 12'd2000;
      port_a_pins = 6'h3f;
      failures = 0;
      tests_run = 0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      // reset state
      apb(1'b0, A_CTRL, 8'h00);
      chk("ctrl", 32'h0, rd);
      apb(1'b0, A_VREF, 8'h00);
      chk("vref", 32'h0, rd);
      apb(1'b0, A_DIR, 8'h00);
      chk("dir", 32'h3f, rd);
      chk("ladder_on", 32'h0, ladder_on);
      done("reset");
      // every mode code, pin 2 set as output; irq enable stays 0 meanwhile
      apb(1'b1, A_DIR, 8'h3b);
      for (int m = 0; m < 8; m++)
      begin
         apb(1'b1, A_CTRL, m[7:0]);
         chk("comp_on", (m != 0 && m != 7), comp_on);
         chk("ref_to_input", (m >= 3 && m <= 6), ref_to_input);
         chk("pin_oe", (m == 1 || m == 3 || m == 5), pin_oe);
         chk("analog_sel", amask[m], analog_sel);
         apb(1'b0, A_PORT, 8'h00);
         chk("port", {26'h0, ~amask[m]}, rd);
      end
      done("modes");
      // polarity, read-only result and unclocked pin drive in mode 1
      apb(1'b1, A_CTRL, 8'h01);
      @(posedge sys_clk);
      vin_pos <= 12'd3000;
      #1;
      chk("pin", 32'h1, pin_level);
      apb(1'b0, A_CTRL, 8'h00);
      chk("ctrl", 32'h41, rd);
      apb(1'b1, A_CTRL, 8'h51);
      chk("pin", 32'h0, pin_level);
      apb(1'b0, A_CTRL, 8'h00);
      chk("ctrl", 32'h11, rd);
      @(posedge sys_clk);
      vin_pos <= 12'd500;
      #1;
      chk("pin", 32'h1, pin_level);
      apb(1'b1, A_DIR, 8'h3f);
      chk("pin_oe", 32'h0, pin_oe);
      done("polarity");
      // reference ladder ranges and power down
      apb(1'b1, A_VREF, 8'hff);
      apb(1'b0, A_VREF, 8'h00);
      chk("vref", 32'haf, rd);
      chk("tap", 32'h0f, ladder_tap);
      apb(1'b1, A_VREF, 8'h05);
      chk("ladder_on", 32'h0, ladder_on);
      apb(1'b1, A_VREF, 8'h85);
      chk("tap", 32'h15, ladder_tap);
      chk("ladder_on", 32'h1, ladder_on);
      apb(1'b1, A_CTRL, 8'h0a);
      chk("cis", 32'h1, neg_from_cis);
      done("reference");
      // change flag, interrupt and wake from sleep
      apb(1'b1, A_CTRL, 8'h02);
      apb(1'b1, A_EN, 8'h01);
      apb(1'b0, A_CTRL, 8'h00);
      apb(1'b1, A_FLAG, 8'h00);
      apb(1'b1, A_CLR, 8'h01);
      chk("irq", 32'h0, irq);
      @(posedge sys_clk);
      sleep <= 1'b1;
      vin_pos <= 12'd3000;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("irq", 32'h1, irq);
      chk("wake", 32'h1, wake);
      chk("comp_on", 32'h1, comp_on);
      chk("ladder_on", 32'h1, ladder_on);
      apb(1'b1, A_FLAG, 8'h00);
      apb(1'b0, A_FLAG, 8'h00);
      chk("flag", 32'h1, rd);
      apb(1'b1, A_EN, 8'h00);
      chk("irq", 32'h0, irq);
      apb(1'b1, A_EN, 8'h01);
      apb(1'b0, A_CTRL, 8'h00);
      chk("ctrl", 32'h42, rd);
      apb(1'b1, A_FLAG, 8'h00);
      apb(1'b0, A_FLAG, 8'h00);
      chk("flag", 32'h0, rd);
      apb(1'b1, A_CLR, 8'h01);
      chk("irq", 32'h0, irq);
      apb(1'b1, A_FLAG, 8'h01);
      apb(1'b0, A_FLAG, 8'h00);
      chk("flag", 32'h1, rd);
      @(posedge sys_clk);
      sleep <= 1'b0;
      apb(1'b0, A_CTRL, 8'h00);
      chk("ctrl", 32'h42, rd);
      apb(1'b0, A_VREF, 8'h00);
      chk("vref", 32'h85, rd);
      done("flag_sleep");
      // unmapped address is refused
      apb(1'b1, 12'hffc, 8'h5a);
      apb(1'b0, 12'hffc, 8'h00);
      chk("pslverr", 32'h1, err);
      chk("unmapped", 32'h0, rd);
      done("unmapped");
      results();
   end
endmodule
